// ===== pkg/bafs_pkg.sv
// Package for the brake arm fault supervisor: register map, fields, timing.
// Assumes a 50 MHz system clock and an Avalon-MM slave with 32-bit data.
// Notes on behaviour
// R1: Both brake arm feedback inputs are always watched and no setting can turn that off.
// R2: A failed lift at start is cleared by itself after 5 s and retried, up to 3 tries.
// R3: After the third failed start try the brake arm fault latches and stays.
// R4: A wrong release at stop latches the brake arm fault at once, with no retry.
// R5: Any wrong lift or release commands door close and stops the car running.
// R6: Door opening is held off while either arm switch is out of place, and freed once both are back.
// R7: The latched fault survives power loss, so its state lives in non-volatile storage.
// R8: Holding both inspection buttons over 5 s in inspection mode clears latched faults.
// R9: A braking force failure raises its own fault, closes the door, stops the car; the same gesture clears it.
// R10: Leaving the door zone with the lock open cuts the safety loop, drive power and drops the brake.
// R11: Inside the door zone the lock loop is bypassed only while early opening or re-levelling holds.
// R12: Car or car-top inspection switches win over the cabinet buttons, which are then ignored.
// R13: The start retry count goes to zero after a good start and when a latched fault clears; here only on leaving ST_LATCH, not for a force fault alone.
// R14: The hold timer restarts when either button is let go early or inspection mode is left.
package bafs_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned RETRY_WAIT_S = 5;
    localparam int unsigned HOLD_TIME_S = 5;
    localparam int unsigned RETRY_CYC = CLK_HZ * RETRY_WAIT_S;
    localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_TIME_S;
    localparam logic [1:0] MAX_TRIES = 2'h3;

    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hC;
    localparam logic [31:0] RESET_CTRL = 32'h0000_0000;
    localparam logic [31:0] RESET_MASK = 32'h0000_0000;

    // Ctrl bits
    localparam int unsigned CTRL_OPEN_REQ = 0;
    localparam int unsigned CTRL_EARLY_OPEN = 1;
    localparam int unsigned CTRL_RELEVEL = 2;
    // Event bits in irq status and mask
    localparam int unsigned EV_ARM_FAULT = 0;
    localparam int unsigned EV_FORCE_FAULT = 1;
    localparam int unsigned EV_SAFETY_CUT = 2;
    localparam int unsigned EV_RETRY = 3;
    localparam int unsigned EV_W = 4;

    typedef struct packed {
        logic car_start;
        logic car_stop;
        logic arm_feedback_a;
        logic arm_feedback_b;
    } bafs_brake_t;

    typedef struct packed {
        logic inspection_mode;
        logic car_inspect_active;
        logic inspect_up_input;
        logic inspect_down_input;
    } bafs_inspect_t;

    typedef struct packed {
        logic door_zone;
        logic door_lock_closed;
    } bafs_door_t;

    typedef struct packed {
        logic arm_fault;
        logic force_fault;
    } bafs_nv_t;

    function automatic logic [3:0] bafs_ofs(input logic [3:0] a);
        return {a[3:2], 2'h0};
    endfunction

endpackage

// ===== rtl/bafs_hold_timer.sv
// Hold timer for the clearing gesture: counts while both buttons held.
// Assumes inputs already synchronous to ref_clk_i.
`timescale 1ns/1ps
module bafs_hold_timer (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic hold_i,
    output logic done_o
);
    import bafs_pkg::*;

    logic [27:0] cnt_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 28'h0;
            done_o <= 1'b0;
        end else if (!hold_i) begin
            cnt_q <= 28'h0; // [R14]
            done_o <= 1'b0;
        end else begin
            // Strictly more than the hold time, then one pulse
            if (cnt_q <= HOLD_CYC[27:0]) begin
                cnt_q <= cnt_q + 28'h1;
            end
            done_o <= (cnt_q == HOLD_CYC[27:0]); // [R8]
        end
    end
endmodule // bafs_hold_timer

// ===== rtl/bafs_supervisor.sv
// Brake arm fault supervisor top: retry/latch logic, door and loop control.
// Assumes inputs synchronous to ref_clk_i and an external non-volatile store
// that returns the saved latch state and is written through nv_wr_o.
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module bafs_supervisor #(
    parameter int unsigned RETRY_CYCLES = bafs_pkg::RETRY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire bafs_pkg::bafs_brake_t brake_i,
    input wire bafs_pkg::bafs_inspect_t inspect_i,
    input wire bafs_pkg::bafs_door_t door_i,
    input wire logic force_fail_i,
    input wire bafs_pkg::bafs_nv_t nv_rd_i,
    input wire logic nv_valid_i,
    output bafs_pkg::bafs_nv_t nv_wr_o,
    output logic nv_we_o,
    output logic door_close_o,
    output logic door_open_ok_o,
    output logic run_enable_o,
    output logic safety_loop_o,
    output logic drive_power_o,
    output logic brake_lift_o,
    output logic lock_bypass_o,
    output logic irq_o
);
    import bafs_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_LATCH = 4'b0100,
        ST_RUN = 4'b1000
    } bafs_state_t;

    bafs_state_t state_q;
    logic [27:0] wait_q;
    logic [1:0] tries_q;
    logic arm_lat_q, force_lat_q, loaded_q;
    logic [31:0] ctrl_q;
    logic [EV_W-1:0] ev_q, mask_q;
    logic cut_q;
    logic clear_done, hold;
    logic arms_up, arms_down, start_bad, stop_bad;
    logic ev_arm, ev_retry, ev_cut, any_fault;
    logic [EV_W-1:0] ev_set;

    // Both arm inputs always used; nothing masks them
    assign arms_up = brake_i.arm_feedback_a & brake_i.arm_feedback_b; // [R1]
    assign arms_down = ~brake_i.arm_feedback_a & ~brake_i.arm_feedback_b; // [R1]
    assign start_bad = brake_i.car_start & ~arms_up;
    assign stop_bad = brake_i.car_stop & ~arms_down;
    // Car switches take the buttons away from the cabinet
    assign hold = inspect_i.inspection_mode & ~inspect_i.car_inspect_active // [R12]
                  & inspect_i.inspect_up_input & inspect_i.inspect_down_input; // [R14]
    assign any_fault = arm_lat_q | force_lat_q | (state_q == ST_WAIT);

    bafs_hold_timer u_hold (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .hold_i(hold),
        .done_o(clear_done)
    );

    // Retry and latch sequencing
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            wait_q <= 28'h0;
            tries_q <= 2'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (arm_lat_q) begin
                        state_q <= ST_LATCH;
                    end else if (stop_bad) begin
                        state_q <= ST_LATCH; // [R4]
                    end else if (start_bad) begin
                        wait_q <= 28'h0;
                        if (tries_q == MAX_TRIES - 2'h1) begin
                            state_q <= ST_LATCH; // [R3]
                        end else begin
                            tries_q <= tries_q + 2'h1;
                            state_q <= ST_WAIT; // [R2]
                        end
                    end else if (brake_i.car_start) begin
                        tries_q <= 2'h0; // [R13]
                        state_q <= ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (wait_q >= RETRY_CYCLES[27:0] - 28'h1) begin
                        state_q <= ST_IDLE; // [R2]
                    end else begin
                        wait_q <= wait_q + 28'h1;
                    end
                end
                ST_RUN: begin
                    if (stop_bad) begin
                        state_q <= ST_LATCH; // [R4]
                    end else if (brake_i.car_stop) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_LATCH: begin
                    if (clear_done) begin
                        tries_q <= 2'h0; // [R13]
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign ev_arm = (state_q != ST_LATCH) & ~arm_lat_q &
                    (((state_q == ST_IDLE) & (stop_bad | (start_bad &
                    (tries_q == MAX_TRIES - 2'h1)))) | ((state_q == ST_RUN) & stop_bad));
    assign ev_retry = (state_q == ST_IDLE) & ~arm_lat_q & ~stop_bad & start_bad &
                      (tries_q != MAX_TRIES - 2'h1);

    // Latches, loaded from non-volatile store after reset
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arm_lat_q <= 1'b0;
            force_lat_q <= 1'b0;
            loaded_q <= 1'b0;
            nv_we_o <= 1'b0;
            nv_wr_o <= '0;
        end else begin
            nv_we_o <= 1'b0;
            if (!loaded_q) begin
                if (nv_valid_i) begin
                    arm_lat_q <= nv_rd_i.arm_fault; // [R7]
                    force_lat_q <= nv_rd_i.force_fault; // [R7]
                    loaded_q <= 1'b1;
                end
            end else if (clear_done) begin
                arm_lat_q <= 1'b0; // [R8]
                force_lat_q <= 1'b0; // [R9]
                nv_wr_o <= '0;
                nv_we_o <= arm_lat_q | force_lat_q; // [R7]
            end else if (ev_arm | force_fail_i) begin
                arm_lat_q <= arm_lat_q | ev_arm; // [R3]
                force_lat_q <= force_lat_q | force_fail_i; // [R9]
                nv_wr_o <= '{arm_fault: arm_lat_q | ev_arm,
                             force_fault: force_lat_q | force_fail_i};
                nv_we_o <= 1'b1; // [R7]
            end
        end
    end

    // Door zone and lock supervision
    assign ev_cut = ~door_i.door_zone & ~door_i.door_lock_closed & ~cut_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cut_q <= 1'b0;
            lock_bypass_o <= 1'b0;
        end else begin
            if (ev_cut) begin
                cut_q <= 1'b1; // [R10]
            end else if (door_i.door_lock_closed) begin
                cut_q <= 1'b0;
            end
            lock_bypass_o <= door_i.door_zone &
                             (ctrl_q[CTRL_EARLY_OPEN] | ctrl_q[CTRL_RELEVEL]); // [R11]
        end
    end

    // Car outputs; all registered
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            door_close_o <= 1'b0;
            door_open_ok_o <= 1'b0;
            run_enable_o <= 1'b0;
            safety_loop_o <= 1'b0;
            drive_power_o <= 1'b0;
            brake_lift_o <= 1'b0;
        end else begin
            door_close_o <= any_fault; // [R5] [R9]
            // Arms must sit released while the car stands
            door_open_ok_o <= ctrl_q[CTRL_OPEN_REQ] & arms_down; // [R6]
            run_enable_o <= loaded_q & ~any_fault & ~cut_q; // [R5] [R9]
            safety_loop_o <= ~cut_q & ~ev_cut; // [R10]
            drive_power_o <= ~cut_q & ~ev_cut & ~any_fault; // [R10]
            brake_lift_o <= ~cut_q & ~ev_cut & ~any_fault & (state_q == ST_RUN); // [R10]
        end
    end

    // Avalon slave: one wait state per access
    assign ev_set = {ev_retry, ev_cut, force_fail_i & ~force_lat_q, ev_arm};
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
            ctrl_q <= RESET_CTRL;
            mask_q <= RESET_MASK[EV_W-1:0];
            ev_q <= '0;
        end else begin
            avs_waitrequest_o <= 1'b1;
            ev_q <= ev_q | ev_set;
            if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= 32'h0;
                if (avs_write_i & avs_byteenable_i[0]) begin
                    case (bafs_ofs(avs_address_i))
                        OFS_CTRL: ctrl_q <= {29'h0, avs_writedata_i[2:0]};
                        // Set wins over the clear
                        OFS_IRQ_STAT: ev_q <= (ev_q & ~avs_writedata_i[EV_W-1:0]) | ev_set;
                        OFS_IRQ_MASK: mask_q <= avs_writedata_i[EV_W-1:0];
                        default: ;
                    endcase
                end else if (avs_read_i) begin
                    case (bafs_ofs(avs_address_i))
                        OFS_CTRL: avs_readdata_o <= ctrl_q;
                        OFS_STATUS: avs_readdata_o <= {22'h0, tries_q, state_q, cut_q,
                                                      loaded_q, force_lat_q, arm_lat_q};
                        OFS_IRQ_STAT: avs_readdata_o <= {28'h0, ev_q};
                        OFS_IRQ_MASK: avs_readdata_o <= {28'h0, mask_q};
                        default: avs_readdata_o <= 32'h0;
                    endcase
                end
            end
            if (!avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(ev_q & mask_q);
        end
    end
endmodule // bafs_supervisor

// ===== sim/bafs_brake_model.sv
// Brake arm feedback switches standing beside the supervisor.
// Assumes the bench commands lift and a stuck arm; switches settle one cycle late.
`timescale 1ns/1ps
module bafs_brake_model (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic lift_i,
    input wire logic stuck_i,
    output logic fb_a_o,
    output logic fb_b_o
);
    // A stuck arm b always shows the wrong state: down at start, up at stop
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fb_a_o <= 1'b0;
            fb_b_o <= 1'b0;
        end else begin
            fb_a_o <= lift_i;
            fb_b_o <= lift_i ^ stuck_i;
        end
    end
endmodule // bafs_brake_model

// ===== sim/bafs_supervisor_asserts.sv
// Checker for the supervisor: bus timing, fault reactions, door and loop control.
// Assumes it is bound to bafs_supervisor and sees only its ports.
`timescale 1ns/1ps
module bafs_supervisor_asserts (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire bafs_pkg::bafs_brake_t brake_i,
    input wire bafs_pkg::bafs_door_t door_i,
    input wire logic force_fail_i,
    input wire logic nv_valid_i,
    input wire logic door_close_o,
    input wire logic door_open_ok_o,
    input wire logic run_enable_o,
    input wire logic safety_loop_o,
    input wire logic drive_power_o,
    input wire logic brake_lift_o,
    input wire logic lock_bypass_o
);
    import bafs_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    logic nv_seen_q;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) nv_seen_q <= 1'b0;
        else if (nv_valid_i) nv_seen_q <= 1'b1;
    end
    AST_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
        !avs_waitrequest_o) else $error("bus request not answered next cycle");
    AST_ONE_CYCLE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_START_BAD: assert property (
        brake_i.car_start && !(brake_i.arm_feedback_a && brake_i.arm_feedback_b)
        |-> ##[1:3] (door_close_o && !run_enable_o)) else $error("bad start not blocked");
    AST_STOP_BAD: assert property (
        brake_i.car_stop && (brake_i.arm_feedback_a || brake_i.arm_feedback_b)
        |-> ##[1:3] (door_close_o && !run_enable_o)) else $error("bad stop not latched");
    AST_FORCE: assert property (
        force_fail_i |-> ##[1:3] (door_close_o && !run_enable_o))
        else $error("force fault not acted on");
    AST_CUT: assert property (
        !door_i.door_zone && !door_i.door_lock_closed
        |=> !safety_loop_o && !drive_power_o && !brake_lift_o)
        else $error("open lock outside zone not cut");
    AST_BYPASS: assert property (lock_bypass_o |-> $past(door_i.door_zone))
        else $error("lock bypass outside door zone");
    AST_DOOR_OK: assert property (
        door_open_ok_o |-> !$past(brake_i.arm_feedback_a) && !$past(brake_i.arm_feedback_b))
        else $error("door opening allowed with arm out of place");
    AST_NV_WAIT: assert property (!nv_seen_q |-> !run_enable_o)
        else $error("running before saved latches loaded");
    cover property (brake_i.car_start && !brake_i.arm_feedback_b);
    cover property (force_fail_i ##1 door_close_o);
    cover property (lock_bypass_o);
endmodule // bafs_supervisor_asserts

bind bafs_supervisor bafs_supervisor_asserts i_bafs_supervisor_asserts (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .brake_i(brake_i),
    .door_i(door_i), .force_fail_i(force_fail_i), .nv_valid_i(nv_valid_i),
    .door_close_o(door_close_o), .door_open_ok_o(door_open_ok_o),
    .run_enable_o(run_enable_o), .safety_loop_o(safety_loop_o),
    .drive_power_o(drive_power_o), .brake_lift_o(brake_lift_o),
    .lock_bypass_o(lock_bypass_o));

// ===== sim/testbench.sv
// Self-checking bench for the supervisor: bus tasks, fault, door and loop tests.
// Assumes the brake switch model and a short retry wait parameter.
`timescale 1ns/1ps
module testbench;
    import bafs_pkg::*;
    localparam int unsigned RCYC = 20;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0, wr = 1'b0, nv_valid = 1'b0;
    logic start = 1'b0, stop = 1'b0, ffail = 1'b0, lift = 1'b0, stuck = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] insp = 4'h0;
    logic [31:0] rdat, junk;
    logic wreq, irq, dclose, dok, run, loop, pwr, blift, byp, nv_we, fb_a, fb_b;
    bafs_nv_t nv_wr;
    bafs_nv_t nv_rd = 2'h0;
    bafs_door_t door = 2'h3;
    int error_cnt = 0;
    int check_count = 0;
    int i;
    always #10 ref_clk_i = ~ref_clk_i;
    bafs_brake_model i_bafs_brake_model (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .lift_i(lift), .stuck_i(stuck), .fb_a_o(fb_a), .fb_b_o(fb_b));
    bafs_supervisor #(.RETRY_CYCLES(RCYC)) i_bafs_supervisor (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .brake_i({start, stop, fb_a, fb_b}), .inspect_i(insp),
        .door_i(door), .force_fail_i(ffail), .nv_rd_i(nv_rd), .nv_valid_i(nv_valid),
        .nv_wr_o(nv_wr), .nv_we_o(nv_we), .door_close_o(dclose), .door_open_ok_o(dok),
        .run_enable_o(run), .safety_loop_o(loop), .drive_power_o(pwr),
        .brake_lift_o(blift), .lock_bypass_o(byp), .irq_o(irq));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pin(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask
    // Request held until the rising edge that samples waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        @(posedge ref_clk_i);
        while (wreq !== 1'b0 && n < 50) begin
            @(posedge ref_clk_i);
            n++;
        end
        q = rdat;
        if (n == 50) begin
            error_cnt++;
            give_verdict();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp,
        input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, exp, q & m);
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        case (k)
            0: start <= 1'b1;
            1: stop <= 1'b1;
            2: ffail <= 1'b1;
            default: nv_valid <= 1'b1;
        endcase
        @(posedge ref_clk_i);
        {start, stop, ffail, nv_valid} <= 4'h0;
    endtask
    task automatic do_reset(input bafs_nv_t nv);
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        nv_rd <= nv;
        lift <= 1'b0;
        stuck <= 1'b0;
        door <= 2'h3;
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        pulse(3);
    endtask
    initial begin
        do_reset(2'h0);
        rdchk(OFS_CTRL, 32'hFFFFFFFF, RESET_CTRL, "ctrl reset");
        rdchk(OFS_IRQ_MASK, 32'hFFFFFFFF, RESET_MASK, "mask reset");
        rdchk(OFS_STATUS, 32'h3FF, 32'h014, "status idle");
        $display("register test done");
        bus(1'b1, OFS_IRQ_MASK, 32'h1, junk);
        stuck <= 1'b1;
        lift <= 1'b1;
        for (i = 1; i <= 3; i++) begin
            repeat (2) @(posedge ref_clk_i);
            pulse(0);
            if (i < 3) begin
                rdchk(OFS_STATUS, 32'h3F0, {22'h0, i[1:0], 8'h20}, "retry wait");
                repeat (RCYC + 5) @(posedge ref_clk_i);
                rdchk(OFS_STATUS, 32'h3F0, {22'h0, i[1:0], 8'h10}, "retry over");
            end
        end
        rdchk(OFS_STATUS, 32'hF1, 32'h41, "start latch");
        repeat (2) @(negedge ref_clk_i);
        pin("door close", 1'b1, dclose);
        pin("run enable", 1'b0, run);
        pin("saved arm latch", 1'b1, nv_wr.arm_fault);
        pin("irq raised", 1'b1, irq);
        rdchk(OFS_IRQ_STAT, 32'hF, 32'h9, "irq events");
        bus(1'b1, OFS_IRQ_STAT, 32'h9, junk);
        repeat (2) @(negedge ref_clk_i);
        pin("irq cleared", 1'b0, irq);
        $display("start retry test done");
        do_reset(2'h0);
        stuck <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        pulse(1);
        rdchk(OFS_STATUS, 32'h3F1, 32'h41, "stop latch");
        $display("stop fault test done");
        do_reset(2'h2);
        rdchk(OFS_STATUS, 32'h7, 32'h5, "reloaded latch");
        do_reset(2'h0);
        pulse(2);
        rdchk(OFS_STATUS, 32'h3, 32'h2, "force latch");
        pin("force run enable", 1'b0, run);
        @(posedge ref_clk_i);
        insp <= 4'hB;
        repeat (10) @(posedge ref_clk_i);
        insp <= 4'h0;
        rdchk(OFS_STATUS, 32'h3, 32'h2, "short hold keeps latch");
        $display("latch and force test done");
        do_reset(2'h0);
        stuck <= 1'b1;
        lift <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        pulse(0);
        repeat (RCYC + 5) @(posedge ref_clk_i);
        stuck <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        pulse(0);
        rdchk(OFS_STATUS, 32'h300, 32'h0, "tries cleared");
        repeat (2) @(negedge ref_clk_i);
        pin("run after good start", 1'b1, run);
        pin("brake lift in run", 1'b1, blift);
        $display("good start test done");
        do_reset(2'h0);
        bus(1'b1, OFS_CTRL, 32'h3, junk);
        repeat (2) @(negedge ref_clk_i);
        pin("door open ok", 1'b1, dok);
        pin("lock bypass", 1'b1, byp);
        @(posedge ref_clk_i);
        lift <= 1'b1;
        repeat (3) @(negedge ref_clk_i);
        pin("door held", 1'b0, dok);
        @(posedge ref_clk_i);
        door <= 2'h0;
        repeat (3) @(negedge ref_clk_i);
        pin("bypass off", 1'b0, byp);
        pin("safety loop", 1'b0, loop);
        pin("drive power", 1'b0, pwr);
        rdchk(OFS_STATUS, 32'h8, 32'h8, "loop cut");
        $display("door zone test done");
        give_verdict();
    end
endmodule // testbench
